/* bench/pec_host.sv */
// Purpose: APB host model that reads and writes the diagnostic registers
// Assumes: One transfer at a time, started from a rising edge
// Notes:   No latency assumed; waits for pready, the bench bounds the wait
`timescale 1ns/1ps
`default_nettype none
module pec_host (
   // Clock
   input  wire logic        mclk,
   // APB master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the completing edge land before the caller looks at outputs
      @(negedge mclk);
   endtask
endmodule
`default_nettype wire

/* bench/phy_error_counters_bist_loopback_tb.sv */
// Purpose: Self-checking bench for counters, self-test and loopback select
// Assumes: Event inputs held high count once per cycle
// Notes:   Wrap test runs 65536 checker errors, the bulk of the run
`timescale 1ns/1ps
`default_nettype none
module phy_error_counters_bist_loopback_tb;
   logic        mclk, reset, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        false_carrier_evt, carrier_valid, rx_data_valid;
   logic        rx_symbol_err, mii_loopback, speed_100, bist_err_evt;
   logic        prbs_locked, prbs_sync_lost, gen_active, power_normal;
   logic        prbs_gen_en, prbs_gen_single, prbs_chk_en, irq;
   logic        bist_wrap_pulse, tx_in_loopback;
   logic [4:0]  loopback_sel, c, x;
   int          fail_count, comparisons, cycles, wraps;
   pec_diag u_dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .pslverr, .prdata, .false_carrier_evt,
      .carrier_valid, .rx_data_valid, .rx_symbol_err, .mii_loopback,
      .speed_100, .bist_err_evt, .prbs_locked, .prbs_sync_lost,
      .gen_active, .power_normal, .prbs_gen_en, .prbs_gen_single,
      .prbs_chk_en, .bist_wrap_pulse, .tx_in_loopback, .loopback_sel, .irq);
   pec_host u_host (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .pslverr, .prdata);
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (bist_wrap_pulse === 1'b1) wraps++;
      if (cycles == 80000) begin
         fail_count++;
         $display("Timeout after %0d cycles", cycles);
         results();
      end
   end
   task automatic chk(input string n, input logic [31:0] xp, g);
      comparisons++;
      if (g !== xp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, xp, g);
      end
   endtask
   task automatic rd(input logic [11:0] a);
      u_host.xfer(1'b0, a, 32'h0, q, e);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, q, e);
   endtask
   task automatic drv(input int k, input logic v);
      case (k)
         0: false_carrier_evt <= v;
         1: {carrier_valid, rx_data_valid, rx_symbol_err} <= {3{v}};
         default: bist_err_evt <= v;
      endcase
   endtask
   // Kind 0 false carrier, 1 receive error, 2 checker error
   task automatic events(input int n, input int k);
      repeat (n) begin
         @(posedge mclk);
         drv(k, 1'b1);
      end
      @(posedge mclk);
      drv(k, 1'b0);
      repeat (2) @(posedge mclk);
   endtask
   task automatic t_reset();
      rd(12'h050); chk("fc reset", 32'h0, q);
      rd(12'h054); chk("rx reset", 32'h0, q);
      rd(12'h058); chk("st reset", 32'h0000_0100, q);
      rd(12'h07C); chk("unmapped", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      $display("test reset done");
   endtask
   task automatic t_fc();
      wr(12'h064, 32'h2);
      events(5, 0); rd(12'h050); chk("fc count", 32'h5, q);
      rd(12'h050); chk("fc cleared", 32'h0, q);
      fork rd(12'h050); begin @(posedge mclk); drv(0, 1'b1);
         @(posedge mclk); drv(0, 1'b0); end join
      rd(12'h050); chk("fc kept", 32'h1, q);
      events(127, 0); chk("fc irq 7F", 32'h0, irq);
      events(1, 0); chk("fc irq 80", 32'h1, irq);
      events(200, 0); rd(12'h050); chk("fc sat", 32'hFF, q);
      rd(12'h060); chk("fc status", 32'h2, q);
      chk("irq cleared", 32'h0, irq);
      wr(12'h064, 32'h0);
      events(130, 0); chk("fc masked", 32'h0, irq);
      rd(12'h050); rd(12'h060);
      $display("test false carrier done");
   endtask
   task automatic t_rx();
      wr(12'h064, 32'h1);
      @(posedge mclk); mii_loopback <= 1'b1;
      events(10, 1); mii_loopback <= 1'b0;
      rd(12'h054); chk("rx loopback", 32'h0, q);
      events(7, 1); rd(12'h054); chk("rx count", 32'h7, q);
      events(300, 1); chk("rx irq", 32'h1, irq);
      rd(12'h054); chk("rx sat", 32'hFF, q);
      rd(12'h060); chk("rx status", 32'h1, q);
      $display("test receive error done");
   endtask
   task automatic t_bist();
      for (int m = 0; m < 4; m++) begin
         wr(12'h058, 32'(m) << 12);
         x = (m == 1) ? 5'h6 : (m == 2) ? 5'h1 : (m == 3) ? 5'h5 : 5'h0;
         chk("test mode", x, {prbs_gen_en, prbs_gen_single, prbs_chk_en});
      end
      @(posedge mclk); {prbs_locked, gen_active, power_normal} <= 3'b110;
      prbs_sync_lost <= 1'b1;
      @(posedge mclk); prbs_sync_lost <= 1'b0;
      rd(12'h058); chk("st status", 32'h3E00, q);
      rd(12'h058); chk("sync sticky", 32'h3A00, q);
      @(posedge mclk); {prbs_locked, gen_active, power_normal} <= 3'b001;
      wr(12'h064, 32'h4); wr(12'h058, 32'h6000);
      wraps = 0; events(65536, 2);
      chk("wrap pulses", 32'h1, wraps);
      rd(12'h060); chk("wrap status", 32'h4, q);
      $display("test self-test done");
   endtask
   task automatic t_loop();
      for (int s = 0; s < 2; s++) for (int i = 0; i < 6; i++) begin
         c = (i == 5) ? 5'h03 : 5'h01 << i;
         x = ((c == 5'h01) ? !s : (c == 5'h04) ? s : (i < 5)) ? c : 5'h00;
         @(posedge mclk); speed_100 <= s[0];
         wr(12'h058, {27'h0, c}); chk("loop sel", x, loopback_sel);
      end
      @(posedge mclk); mii_loopback <= 1'b1;
      wr(12'h058, 32'h40); chk("tx loop", 32'h1, tx_in_loopback);
      @(posedge mclk); speed_100 <= 1'b0;
      @(negedge mclk); chk("tx 10M", 32'h0, tx_in_loopback);
      @(posedge mclk); mii_loopback <= 1'b0;
      $display("test loopback done");
   endtask
   task automatic results();
      $display("Counts: %0d compared, %0d mismatched", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      {mclk, false_carrier_evt, carrier_valid, rx_data_valid} = 4'h0;
      {rx_symbol_err, mii_loopback, speed_100, bist_err_evt} = 4'h0;
      {prbs_locked, prbs_sync_lost, gen_active} = 3'h0;
      {reset, power_normal} = 2'h3;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_fc();
      t_rx();
      t_bist();
      t_loop();
      results();
   end
endmodule
`default_nettype wire

/* hdl/pec_diag.sv */
// Purpose: Error counters, self-test control and loopback select of a PHY
// Assumes: Event inputs are single-cycle pulses from logic on mclk
// Notes:   Counters clear on read; interrupt status clears on read
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pec_diag (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Receive path events
   input  wire logic        false_carrier_evt,
   input  wire logic        carrier_valid,
   input  wire logic        rx_data_valid,
   input  wire logic        rx_symbol_err,
   input  wire logic        mii_loopback,
   input  wire logic        speed_100,
   // Self-test engine status
   input  wire logic        bist_err_evt,
   input  wire logic        prbs_locked,
   input  wire logic        prbs_sync_lost,
   input  wire logic        gen_active,
   input  wire logic        power_normal,
   // Self-test and loopback controls
   output logic             prbs_gen_en,
   output logic             prbs_gen_single,
   output logic             prbs_chk_en,
   output logic             bist_wrap_pulse,
   output logic             tx_in_loopback,
   output logic [4:0]       loopback_sel,
   // Interrupt
   output logic             irq
);
   logic [7:0]  fc_count;
   logic [15:0] re_count;
   logic [15:0] bist_count;
   logic [15:0] ctrl;
   logic        sync_lost;
   logic [2:0]  irq_status;
   logic [2:0]  irq_mask;
   logic [9:0]  idx;
   logic        acc;
   logic        rd;
   logic        wr;
   logic        mapped;
   logic        rd_fc;
   logic        rd_re;
   logic        rd_st;
   logic        rd_is;
   logic        re_evt;
   logic        fc_half;
   logic        re_half;
   logic [7:0]  fc_base;
   logic [15:0] re_base;
   logic        bist_wrap;
   logic        bist_stop;
   logic [15:0] status_view;
   pec_pkg::pec_test_e mode;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   assign idx    = paddr[11:2];
   assign acc    = psel && penable;
   assign rd     = acc && !pwrite;
   assign wr     = acc && pwrite;
   assign mapped = (idx == {2'b00, pec_pkg::IDX_FALSE_CARRIER})
                || (idx == {2'b00, pec_pkg::IDX_RECEIVE_ERROR})
                || (idx == {2'b00, pec_pkg::IDX_SELF_TEST})
                || (idx == {2'b00, pec_pkg::IDX_IRQ_STATUS})
                || (idx == {2'b00, pec_pkg::IDX_IRQ_MASK});
   assign rd_fc  = rd && idx == {2'b00, pec_pkg::IDX_FALSE_CARRIER};
   assign rd_re  = rd && idx == {2'b00, pec_pkg::IDX_RECEIVE_ERROR};
   assign rd_st  = rd && idx == {2'b00, pec_pkg::IDX_SELF_TEST};
   assign rd_is  = rd && idx == {2'b00, pec_pkg::IDX_IRQ_STATUS};
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   // Receive error qualified by carrier, valid data and not loopback
   assign re_evt = rx_symbol_err && carrier_valid && rx_data_valid // RQ5
                && !mii_loopback; // RQ6

   // A read removes only what was reported at setup, so an event in the
   // setup cycle is not lost between the snapshot and the clear
   assign fc_base = rd_fc ? fc_count - prdata[7:0] : fc_count; // RQ17
   assign re_base = rd_re ? re_count - prdata[15:0] : re_count; // RQ17

   // Half-full flagged on the step past 7Fh only
   assign fc_half = false_carrier_evt && fc_base == pec_pkg::CNT_HALF; // RQ3
   assign re_half = re_evt && re_base == {8'h00, pec_pkg::CNT_HALF}; // RQ7

   // Read clears; events since the setup cycle land after the clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         fc_count <= 8'h00;
      end else if (rd_fc) begin
         fc_count <= fc_base + {7'h00, false_carrier_evt}; // RQ4 RQ17
      end else if (false_carrier_evt && fc_count != pec_pkg::CNT_MAX) begin
         fc_count <= fc_count + 8'h01; // RQ1 RQ2
      end
   end

   // Receive counter is 16 bits wide but stops at FFh as specified
   always_ff @(posedge mclk) begin
      if (reset) begin
         re_count <= 16'h0000;
      end else if (rd_re) begin
         re_count <= re_base + {15'h0000, re_evt}; // RQ4 RQ17
      end else if (re_evt && re_count != {8'h00, pec_pkg::CNT_MAX}) begin
         re_count <= re_count + 16'h0001; // RQ7
      end
   end

   // Control register; read-only bits are not stored here
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl <= pec_pkg::SELF_TEST_RESET & pec_pkg::SELF_TEST_WMASK;
      end else if (wr && idx == {2'b00, pec_pkg::IDX_SELF_TEST}) begin
         ctrl <= pwdata[15:0] & pec_pkg::SELF_TEST_WMASK; // RQ8 RQ9 RQ15
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_mask <= 3'h0;
      end else if (wr && idx == {2'b00, pec_pkg::IDX_IRQ_MASK}) begin
         irq_mask <= pwdata[2:0];
      end
   end

   assign mode = pec_pkg::pec_test_e'(ctrl[13:12]);
   always_comb begin
      prbs_gen_en     = 1'b0;
      prbs_gen_single = 1'b0;
      prbs_chk_en     = 1'b0;
      unique case (mode)
         pec_pkg::PEC_TEST_OFF: begin
         end
         pec_pkg::PEC_TEST_SINGLE: begin
            prbs_gen_en     = 1'b1; // RQ9
            prbs_gen_single = 1'b1;
         end
         pec_pkg::PEC_TEST_CHECK: begin
            prbs_chk_en = 1'b1; // RQ9
         end
         pec_pkg::PEC_TEST_BOTH: begin
            prbs_gen_en = 1'b1; // RQ9
            prbs_chk_en = 1'b1;
         end
      endcase
   end

   // Self-test error count: stop at max or wrap with a pulse
   assign bist_stop = bist_count == pec_pkg::BIST_ERR_MAX;
   assign bist_wrap = prbs_chk_en && bist_err_evt && bist_stop
                   && ctrl[pec_pkg::BIT_ERR_MODE]; // RQ8
   always_ff @(posedge mclk) begin
      if (reset || !prbs_chk_en) begin
         bist_count <= 16'h0000;
      end else if (bist_err_evt) begin
         if (!bist_stop) begin
            bist_count <= bist_count + 16'h0001;
         end else if (ctrl[pec_pkg::BIT_ERR_MODE]) begin
            bist_count <= 16'h0000; // RQ8
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         bist_wrap_pulse <= 1'b0;
      end else begin
         bist_wrap_pulse <= bist_wrap; // RQ8
      end
   end

   // Sync loss is sticky until the register is read; set wins
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync_lost <= 1'b0;
      end else if (prbs_sync_lost) begin
         sync_lost <= 1'b1; // RQ11
      end else if (rd_st) begin
         sync_lost <= 1'b0;
      end
   end

   // Only the five one-hot codes reach the data path
   always_comb begin
      unique case (ctrl[4:0])
         5'h00, pec_pkg::LB_PCS_OUT, pec_pkg::LB_ANALOG,
         pec_pkg::LB_REVERSE:
            loopback_sel = ctrl[4:0]; // RQ15
         pec_pkg::LB_PCS_IN:
            loopback_sel = speed_100 ? 5'h00 : ctrl[4:0]; // RQ15
         pec_pkg::LB_DIGITAL:
            loopback_sel = speed_100 ? ctrl[4:0] : 5'h00; // RQ15
         default:
            loopback_sel = 5'h00;
      endcase
   end

   // Meaningful only in MII loopback at 100 Mbps
   assign tx_in_loopback = ctrl[pec_pkg::BIT_TX_LOOP] && mii_loopback
                        && speed_100; // RQ14

   always_comb begin
      status_view = ctrl;
      status_view[pec_pkg::BIT_LOCK]       = prbs_locked; // RQ10
      status_view[pec_pkg::BIT_SYNC_LOSS]  = sync_lost; // RQ11
      status_view[pec_pkg::BIT_GEN_ACTIVE] = gen_active; // RQ12
      status_view[pec_pkg::BIT_POWER]      = power_normal; // RQ13
   end

   // Sticky status, cleared by a read; a new event wins over the clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_status <= 3'h0;
      end else begin
         irq_status[pec_pkg::BIT_IRQ_RXERR] <= re_half
            || (irq_status[pec_pkg::BIT_IRQ_RXERR] && !rd_is);
         irq_status[pec_pkg::BIT_IRQ_FCARR] <= fc_half
            || (irq_status[pec_pkg::BIT_IRQ_FCARR] && !rd_is);
         irq_status[pec_pkg::BIT_IRQ_BIST]  <= bist_wrap
            || (irq_status[pec_pkg::BIT_IRQ_BIST] && !rd_is);
      end
   end
   assign irq = |(irq_status & irq_mask); // RQ16

   always_ff @(posedge mclk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr[11:2])
            {2'b00, pec_pkg::IDX_FALSE_CARRIER}:
               prdata <= {24'h000000, fc_count}; // RQ4
            {2'b00, pec_pkg::IDX_RECEIVE_ERROR}:
               prdata <= {16'h0000, re_count}; // RQ4
            {2'b00, pec_pkg::IDX_SELF_TEST}:
               prdata <= {16'h0000, status_view};
            {2'b00, pec_pkg::IDX_IRQ_STATUS}:
               prdata <= {29'h0, irq_status};
            {2'b00, pec_pkg::IDX_IRQ_MASK}:
               prdata <= {29'h0, irq_mask};
            default:
               prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Counter checks; a read keeps events that followed the snapshot
   a_fc_saturate: assert property ( // RQ2
      fc_count == pec_pkg::CNT_MAX && !rd_fc
      |=> fc_count == pec_pkg::CNT_MAX)
      else $error("false carrier count left FFh");
   a_fc_count_step: assert property ( // RQ1
      false_carrier_evt && !rd_fc && fc_count < pec_pkg::CNT_MAX
      |=> fc_count == $past(fc_count) + 8'h01)
      else $error("false carrier count missed event");
   a_fc_idle_hold: assert property ( // RQ1
      !false_carrier_evt && !rd_fc
      |=> fc_count == $past(fc_count))
      else $error("false carrier count moved without event");
   a_fc_half_flag: assert property ( // RQ3
      fc_half |=> irq_status[pec_pkg::BIT_IRQ_FCARR])
      else $error("false carrier half-full not flagged");
   a_fc_half_edge: assert property ( // RQ3
      false_carrier_evt && !rd_fc && fc_count == pec_pkg::CNT_HALF
      |-> fc_half)
      else $error("false carrier step past 7Fh not seen");
   a_fc_read_clear: assert property ( // RQ4 RQ17
      rd_fc |=> fc_count == $past(fc_count) - $past(prdata[7:0])
                + $past(false_carrier_evt))
      else $error("false carrier read lost or kept events");
   a_rd_data_fc: assert property ( // RQ4
      psel && !penable && !pwrite
      && idx == {2'b00, pec_pkg::IDX_FALSE_CARRIER}
      |=> prdata == {24'h000000, $past(fc_count)})
      else $error("false carrier read data wrong");
   a_read_clears: assert property ( // RQ4 RQ17
      rd_re |=> re_count == $past(re_count) - $past(prdata[15:0])
                + $past(re_evt))
      else $error("receive count not cleared by read");
   a_re_count_step: assert property ( // RQ5
      re_evt && !rd_re && re_count < {8'h00, pec_pkg::CNT_MAX}
      |=> re_count == $past(re_count) + 16'h0001)
      else $error("receive count missed error");
   a_re_idle_hold: assert property ( // RQ5
      !re_evt && !rd_re
      |=> $stable(re_count))
      else $error("receive count moved without error");
   a_re_loop_hold: assert property ( // RQ6
      mii_loopback && !rd_re
      |=> re_count == $past(re_count))
      else $error("receive count moved in loopback");
   a_re_cap: assert property ( // RQ7
      re_count <= {8'h00, pec_pkg::CNT_MAX})
      else $error("receive count passed FFh");
   a_re_sat: assert property ( // RQ7
      re_count == {8'h00, pec_pkg::CNT_MAX} && !rd_re
      |=> re_count == {8'h00, pec_pkg::CNT_MAX})
      else $error("receive count left FFh");
   a_re_half_edge: assert property ( // RQ7
      re_evt && !rd_re && re_count == {8'h00, pec_pkg::CNT_HALF}
      |-> re_half)
      else $error("receive step past 7Fh not seen");
   a_re_half_flag: assert property ( // RQ7
      re_half
      |=> irq_status[pec_pkg::BIT_IRQ_RXERR])
      else $error("receive half-full not flagged");

   // Self-test control and status checks
   a_wrap_count: assert property ( // RQ8
      bist_wrap
      |=> bist_count == 16'h0000 && bist_wrap_pulse)
      else $error("self-test count did not wrap");
   a_bist_stop_hold: assert property ( // RQ8
      prbs_chk_en && bist_stop && !ctrl[pec_pkg::BIT_ERR_MODE]
      |=> bist_count == pec_pkg::BIST_ERR_MAX)
      else $error("self-test count left max in single mode");
   a_wrap_pulse_one: assert property ( // RQ8
      bist_wrap_pulse
      |=> !bist_wrap_pulse)
      else $error("wrap pulse longer than one cycle");
   a_chk_mode: assert property ( // RQ9
      prbs_chk_en == ctrl[13])
      else $error("checker enable wrong for mode");
   a_gen_mode: assert property ( // RQ9
      prbs_gen_en == ctrl[12])
      else $error("generator enable wrong for mode");
   a_single_mode: assert property ( // RQ9
      prbs_gen_single == (ctrl[13:12] == 2'h1))
      else $error("single packet select wrong for mode");
   a_bist_off_clear: assert property ( // RQ9
      !prbs_chk_en
      |=> bist_count == 16'h0000)
      else $error("self-test count kept with checker off");
   a_ctrl_write: assert property ( // RQ9
      wr && idx == {2'b00, pec_pkg::IDX_SELF_TEST}
      |=> ctrl == ($past(pwdata[15:0]) & pec_pkg::SELF_TEST_WMASK))
      else $error("self-test control write lost");
   a_sync_set: assert property ( // RQ11
      prbs_sync_lost
      |=> sync_lost)
      else $error("sync loss not latched");
   a_sync_clear: assert property ( // RQ11
      rd_st && !prbs_sync_lost
      |=> !sync_lost)
      else $error("sync loss not cleared by read");

   // Interrupt and loopback checks
   a_irq_gate: assert property ( // RQ16
      irq |-> (irq_status & irq_mask) != 3'h0 && irq_mask != 3'h0)
      else $error("interrupt without enabled status");
   a_status_clear: assert property ( // RQ16
      rd_is && !re_half && !fc_half && !bist_wrap
      |=> irq_status == 3'h0)
      else $error("interrupt status not cleared by read");
   a_tx_loop: assert property ( // RQ14
      tx_in_loopback |-> mii_loopback)
      else $error("loopback transmit outside loopback");
   a_tx_speed: assert property ( // RQ14
      tx_in_loopback
      |-> speed_100 && ctrl[pec_pkg::BIT_TX_LOOP])
      else $error("loopback transmit at wrong speed");
   a_loop_onehot: assert property ( // RQ15
      $onehot0(loopback_sel))
      else $error("more than one loopback mode selected");
   a_loop_pcs_in: assert property ( // RQ15
      loopback_sel == pec_pkg::LB_PCS_IN
      |-> !speed_100)
      else $error("pcs input loopback at 100 Mbps");
   a_loop_digital: assert property ( // RQ15
      loopback_sel == pec_pkg::LB_DIGITAL
      |-> speed_100)
      else $error("digital loopback at 10 Mbps");
endmodule
`default_nettype wire

/* hdl/pec_pkg.sv */
// Purpose: Constants for the PHY error counter and self-test register block
// Assumes: APB slave, 32-bit data, printed offsets are register indices
// Notes:   Byte address of a register is four times its index
// Contract
// RQ1 - 8-bit false carrier counter counts events
// RQ2 - False carrier counter saturates at FFh
// RQ3 - False carrier count above 7Fh flags half-full
// RQ4 - Reading a counter returns it, then clears
// RQ5 - Receive errors counted while carrier and valid
// RQ6 - No receive error counting in MII loopback
// RQ7 - Receive counter stops FFh, half-full above 7Fh
// RQ8 - Bit 14 selects self-test counter stop or wrap
// RQ9 - Bits 13:12 select generator and checker operation
// RQ10 - Bit 11 reports checker lock
// RQ11 - Bit 10 reports checker sync loss
// RQ12 - Bit 9 reports packet generator activity
// RQ13 - Bit 8 reports power mode, reset one
// RQ14 - Bit 6 transmits during MII loopback; the code does so only at 100 Mbps
// RQ15 - Five-bit field selects one loopback mode
// RQ16 - Half-full events interrupt only when enabled
// RQ17 - Event during clear-on-read counts after clear
package pec_pkg;
   localparam logic [7:0]  IDX_FALSE_CARRIER = 8'h14;
   localparam logic [7:0]  IDX_RECEIVE_ERROR = 8'h15;
   localparam logic [7:0]  IDX_SELF_TEST     = 8'h16;
   localparam logic [7:0]  IDX_IRQ_STATUS    = 8'h18;
   localparam logic [7:0]  IDX_IRQ_MASK      = 8'h19;
   localparam logic [7:0]  CNT_MAX           = 8'hFF;
   localparam logic [7:0]  CNT_HALF          = 8'h7F;
   localparam logic [15:0] SELF_TEST_RESET   = 16'h0100;
   localparam logic [15:0] SELF_TEST_WMASK   = 16'h705F;
   localparam int          BIT_ERR_MODE      = 14;
   localparam int          BIT_LOCK          = 11;
   localparam int          BIT_SYNC_LOSS     = 10;
   localparam int          BIT_GEN_ACTIVE    = 9;
   localparam int          BIT_POWER         = 8;
   localparam int          BIT_TX_LOOP       = 6;
   localparam int          BIT_IRQ_RXERR     = 0;
   localparam int          BIT_IRQ_FCARR     = 1;
   localparam int          BIT_IRQ_BIST      = 2;
   localparam logic [15:0] BIST_ERR_MAX      = 16'hFFFF;
   localparam logic [4:0]  LB_PCS_IN         = 5'h01;
   localparam logic [4:0]  LB_PCS_OUT        = 5'h02;
   localparam logic [4:0]  LB_DIGITAL        = 5'h04;
   localparam logic [4:0]  LB_ANALOG         = 5'h08;
   localparam logic [4:0]  LB_REVERSE        = 5'h10;
   typedef enum logic [1:0] {
      PEC_TEST_OFF    = 2'h0,
      PEC_TEST_SINGLE = 2'h1,
      PEC_TEST_CHECK  = 2'h2,
      PEC_TEST_BOTH   = 2'h3
   } pec_test_e;
endpackage
